// ===== logic/pgood_pkg.sv
// Constants and types shared by the power-good start-up control block
package pgood_pkg;

   // ----------------------------------------------------------------
   // Pin function selected by the active configuration
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PIN_NONE   = 2'b00,
      PIN_SLEEP  = 2'b01,
      PIN_REBOOT = 2'b10,
      PIN_BOTH   = 2'b11
   } pin_mode_e;

   // ----------------------------------------------------------------
   // Start-up sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_PAUSE   = 3'b000,
      ST_LOAD    = 3'b001,
      ST_RUN     = 3'b010,
      ST_SLEEP   = 3'b011,
      ST_RESTART = 3'b100
   } start_state_e;

   // ----------------------------------------------------------------
   // Widths and values after reset
   // ----------------------------------------------------------------
   localparam int unsigned SLOT_W     = 2;
   localparam logic [1:0]  RST_SLOT   = 2'h0;
   localparam logic        RST_LEVEL  = 1'h0;
   localparam logic        RST_OUTPUT = 1'h0;
   localparam logic        RST_ACTIVE = 1'h1;

endpackage : pgood_pkg

// ===== logic/pgood_sync.sv
// Two-flop synchroniser for the power-good pin
`timescale 1ns/1ps
module pgood_sync
   import pgood_pkg::*;
(
   input  wire logic   i_clk_sys,
   input  wire logic   i_rstn,
   input  wire logic   i_pin,
   pgood_sync_if.src   sync
);

   // ----------------------------------------------------------------
   // Synchroniser
   // ----------------------------------------------------------------
   // Resets low so a pin that is already high still counts as a rise
   logic meta;
   logic level;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         meta  <= RST_LEVEL;
         level <= RST_LEVEL;
      end else begin
         meta  <= i_pin;
         level <= meta;
      end
   end

   assign sync.level = level;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_sync_delay;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      ##2 (level == $past(i_pin, 2));
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("synchronised level does not follow pin by two cycles");

endmodule : pgood_sync

// ===== logic/pgood_sync_if.sv
// Carrier for the synchronised power-good level between the two modules
`timescale 1ns/1ps
interface pgood_sync_if;
   logic level;

   modport src (output level);
   modport dst (input  level);
endinterface : pgood_sync_if

// ===== logic/power_good_startup_control.sv
// Start-up sequencer steered by the multi-function power-good pin
`timescale 1ns/1ps
module power_good_startup_control
   import pgood_pkg::*;
(
   input  wire logic              i_clk_sys,
   input  wire logic              i_rstn,
   input  wire logic              i_power_ok_pin,
   input  wire logic [1:0]        i_pin_mode,
   input  wire logic [SLOT_W-1:0] i_cfg_select,
   input  wire logic              i_supplies_valid,
   input  wire logic              i_eeprom_code,
   input  wire logic              i_load_done,
   output logic                   o_load_req,
   output logic                   o_load_from_eeprom,
   output logic [SLOT_W-1:0]      o_load_slot,
   output logic                   o_pll_enable,
   output logic                   o_logic_enable,
   output logic                   o_outputs_enable,
   output logic                   o_core_reset,
   output logic                   o_startup_paused
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   pgood_sync_if sync_link ();

   pgood_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .i_pin     (i_power_ok_pin),
      .sync      (sync_link.src)
   );

   wire logic pin_high = sync_link.level;

   // ----------------------------------------------------------------
   // Pin function decode
   // ----------------------------------------------------------------
   // A configuration naming both functions is taken as neither, so the
   // pin can never sleep and reboot the device at once
   wire logic sleep_mode  = (i_pin_mode == PIN_SLEEP);
   wire logic reboot_mode = (i_pin_mode == PIN_REBOOT);
   wire logic no_function = !sleep_mode && !reboot_mode;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   start_state_e state;
   start_state_e next_state;

   always_comb begin
      next_state = state;
      case (state)
         ST_PAUSE: begin
            if (no_function ? i_supplies_valid : pin_high) begin
               next_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (reboot_mode && !pin_high) begin
               next_state = ST_RESTART;
            end else if (i_load_done) begin
               next_state = (sleep_mode && !pin_high) ? ST_SLEEP : ST_RUN;
            end
         end
         ST_RUN: begin
            if (sleep_mode && !pin_high) begin
               next_state = ST_SLEEP;
            end else if (reboot_mode && !pin_high) begin
               next_state = ST_RESTART;
            end
         end
         ST_SLEEP: begin
            if (pin_high) begin
               next_state = ST_RUN;
            end
         end
         ST_RESTART: begin
            if (pin_high) begin
               next_state = ST_LOAD;
            end
         end
         default: begin
            next_state = ST_PAUSE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= ST_PAUSE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Output decode, registered from the next state
   // ----------------------------------------------------------------
   wire logic start_load  = (next_state == ST_LOAD) && (state != ST_LOAD);
   wire logic next_active = (next_state == ST_RUN) || (next_state == ST_LOAD);
   wire logic next_gate   = (next_state == ST_RUN) &&
                            (!no_function || i_supplies_valid);
   wire logic next_logic  = (next_state != ST_SLEEP);
   wire logic next_reset  = (next_state == ST_RESTART);
   wire logic next_paused = (next_state == ST_PAUSE) ||
                            (next_state == ST_RESTART);

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_load_req       <= RST_OUTPUT;
         o_pll_enable     <= RST_OUTPUT;
         o_logic_enable   <= RST_ACTIVE;
         o_outputs_enable <= RST_OUTPUT;
         o_core_reset     <= RST_OUTPUT;
         o_startup_paused <= RST_ACTIVE;
      end else begin
         o_load_req       <= start_load;
         o_pll_enable     <= next_active;
         o_logic_enable   <= next_logic;
         o_outputs_enable <= next_gate;
         o_core_reset     <= next_reset;
         o_startup_paused <= next_paused;
      end
   end

   // Slot and source are sampled only when a load starts, so a resume
   // from sleep leaves the loaded configuration untouched
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_load_slot        <= RST_SLOT;
         o_load_from_eeprom <= RST_OUTPUT;
      end else if (start_load) begin
         o_load_slot        <= i_cfg_select;
         o_load_from_eeprom <= i_eeprom_code;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_pause_hold;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (state == ST_PAUSE && !no_function && !pin_high)
         |=> (state == ST_PAUSE) && o_startup_paused;
   endproperty
   a_pause_hold: assert property (p_pause_hold)
      else $error("start-up left pause while pin low");

   property p_first_load;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (state == ST_PAUSE && sleep_mode && pin_high)
         |=> o_load_req && (o_load_slot == $past(i_cfg_select));
   endproperty
   a_first_load: assert property (p_first_load)
      else $error("first rise did not load selected slot");

   property p_no_reload;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (state == ST_SLEEP && pin_high)
         |=> !o_load_req && (state == ST_RUN) ##1 !o_load_req;
   endproperty
   a_no_reload: assert property (p_no_reload)
      else $error("wake from sleep reloaded configuration");

   property p_sleep_power;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (state == ST_RUN && sleep_mode && !pin_high)
         |=> (state == ST_SLEEP) && !o_pll_enable && !o_logic_enable
             && !o_outputs_enable;
   endproperty
   a_sleep_power: assert property (p_sleep_power)
      else $error("sleep did not switch off PLL and logic");

   property p_resume;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (state == ST_SLEEP && pin_high)
         |=> $stable(o_load_slot) && $stable(o_load_from_eeprom)
             && o_pll_enable;
   endproperty
   a_resume: assert property (p_resume)
      else $error("resume from sleep changed state");

   property p_restart;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (state == ST_RUN && reboot_mode && !pin_high)
         |=> o_core_reset && !o_outputs_enable && (state == ST_RESTART);
   endproperty
   a_restart: assert property (p_restart)
      else $error("reboot low did not reset the device");

   property p_reboot_load;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (state == ST_RESTART && pin_high)
         |=> o_load_req && !o_core_reset ##1 !o_load_req;
   endproperty
   a_reboot_load: assert property (p_reboot_load)
      else $error("reboot release did not load once");

   // Neither or both functions named: a low pin must be ignored in run
   property p_exclusive;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (state == ST_RUN && !pin_high &&
       (i_pin_mode == PIN_NONE || i_pin_mode == PIN_BOTH))
         |=> (state == ST_RUN) && o_logic_enable && !o_core_reset;
   endproperty
   a_exclusive: assert property (p_exclusive)
      else $error("low pin acted on without a single pin function");

   property p_gated;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (no_function && !i_supplies_valid) |=> !o_outputs_enable;
   endproperty
   a_gated: assert property (p_gated)
      else $error("outputs ungated before supplies valid");

   property p_eeprom;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      o_load_req |-> (o_load_from_eeprom == $past(i_eeprom_code));
   endproperty
   a_eeprom: assert property (p_eeprom)
      else $error("EEPROM source not taken from configuration code");

   c_sleep_wake: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state == ST_SLEEP ##1 state == ST_RUN);
   c_reboot: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state == ST_RESTART ##1 state == ST_LOAD);
   c_plain_up: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      no_function && o_outputs_enable);

endmodule : power_good_startup_control

// ===== tb/pgood_ctrl_model.sv
// Behavioural system power controller that drives the power-good pin
`timescale 1ns/1ps
module pgood_ctrl_model #(
   parameter int HOLD_CYC = 4
) (
   input  wire logic i_clk_sys,
   input  wire logic i_supply_up,
   input  wire logic i_want_high,
   output logic      o_power_ok_pin,
   output logic      o_supplies_valid
);
   int   held   = 0;
   logic want_q = 1'b0;

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   assign o_supplies_valid = i_supply_up;
   always @(posedge i_clk_sys) want_q <= i_want_high;
   // Pin is low from time zero, before any supply is up
   // The hold count restarts whenever the supply drops again
   initial begin
      o_power_ok_pin = 1'b0;
      forever begin
         @(negedge i_clk_sys);
         held <= !i_supply_up ? 0 :
                 (held < HOLD_CYC ? held + 1 : held);
         o_power_ok_pin <= want_q && i_supply_up &&
                           held >= HOLD_CYC;
      end
   end
endmodule : pgood_ctrl_model

// ===== tb/tb.sv
// Self-checking bench for the power-good start-up control block
`timescale 1ns/1ps
module tb;
   import pgood_pkg::*;
   logic       clk, rstn, want, sup_up, pin, sup_ok, code, done;
   logic [1:0] mode, sel, slot;
   logic       req, eep, pll, lgc, outs, core, paused;
   int         n_errors = 0;
   int         n_tests  = 0;
   int         loads    = 0;

   // ----------------------------------------------------------------
   // Clock, partner and design
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   pgood_ctrl_model #(.HOLD_CYC(4)) ctl (.i_clk_sys(clk),
      .i_supply_up(sup_up), .i_want_high(want), .o_power_ok_pin(pin),
      .o_supplies_valid(sup_ok));

   power_good_startup_control uut (.i_clk_sys(clk), .i_rstn(rstn),
      .i_power_ok_pin(pin), .i_pin_mode(mode), .i_cfg_select(sel),
      .i_supplies_valid(sup_ok), .i_eeprom_code(code), .i_load_done(done),
      .o_load_req(req), .o_load_from_eeprom(eep), .o_load_slot(slot),
      .o_pll_enable(pll), .o_logic_enable(lgc), .o_outputs_enable(outs),
      .o_core_reset(core), .o_startup_paused(paused));

   // Pulses last one cycle, so they are counted at the edge itself
   always @(posedge clk) if (req === 1'b1) loads <= loads + 1;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step

   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   task automatic do_reset();
      rstn = 1'b0;
      step(3);
      rstn = 1'b1;
   endtask : do_reset

   task automatic end_of_test();
      if (n_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic s_sleep_boot();
      mode = 2'h1;
      sup_up = 1'b1;
      do_reset();
      chk("reset req", 8'h00, {7'h0, req});
      chk("reset", 8'h09, {eep, slot, pll, lgc, outs, core, paused});
      step(8);
      chk("paused low pin", 8'h05, {4'h0, pll, lgc, outs, paused});
      want = 1'b1;
      step(3);
      chk("paused in sync", 8'h01, {7'h0, paused});
      step(1);
      chk("first load", 8'hd4,
          {eep, slot, pll, paused, req, loads[1:0]});
      done = 1'b1;
      step(2);
      chk("run outs", 8'h07, {5'h0, pll, lgc, outs});
   endtask : s_sleep_boot

   task automatic s_sleep_resume();
      sel = 2'h1;
      want = 1'b0;
      step(4);
      chk("sleep state", 8'h00, {5'h0, pll, lgc, outs});
      want = 1'b1;
      step(4);
      chk("resume", 8'hf1,
          {pll, lgc, outs, slot, req, loads[1:0]});
   endtask : s_sleep_resume

   task automatic s_reboot();
      mode = 2'h2;
      code = 1'b0;
      sel = 2'h3;
      want = 1'b0;
      step(4);
      chk("restart state", 8'h06, {5'h0, core, paused, outs});
      want = 1'b1;
      step(4);
      chk("reload", 8'h1d,
          {core, paused, eep, slot, req, loads[1:0]});
      step(1);
      chk("run again", 8'h01, {7'h0, outs});
   endtask : s_reboot

   task automatic s_no_function(input logic [1:0] m);
      mode = m;
      sup_up = 1'b0;
      want = 1'b1;
      do_reset();
      step(6);
      chk("gated outs", 8'h01, {6'h0, outs, paused});
      sup_up = 1'b1;
      // Long enough for the partner to raise the pin before it drops again
      step(6);
      chk("supply outs", 8'h01, {7'h0, outs});
      want = 1'b0;
      step(8);
      chk("pin ignored", 8'h03, {6'h0, pll, outs});
   endtask : s_no_function

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      want = 1'b0;
      sup_up = 1'b0;
      mode = 2'h1;
      sel = 2'h2;
      code = 1'b1;
      done = 1'b0;
      s_sleep_boot();
      s_sleep_resume();
      s_reboot();
      s_no_function(2'h0);
      s_no_function(2'h3);
      end_of_test();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #100us;
      n_errors++;
      end_of_test();
   end
endmodule : tb
